//--- src/pms_pkg.sv
// Package: power states, clock source codes and timing constants
package pms_pkg;
  // Power states of the sequencer
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_IDLE = 3'b001,
    ST_GATE_SB = 3'b010,
    ST_STANDBY = 3'b011,
    ST_GATE_SD = 3'b100,
    ST_SHUTDOWN = 3'b101,
    ST_RESET = 3'b110
  } pms_state_t;
  // Requested low-power mode codes
  localparam logic [1:0] REQ_IDLE = 2'h0;
  localparam logic [1:0] REQ_STANDBY = 2'h1;
  localparam logic [1:0] REQ_SHUTDOWN = 2'h2;
  // Low-speed clock source select codes
  localparam logic [1:0] LF_RC = 2'h0;
  localparam logic [1:0] LF_XTAL = 2'h1;
  localparam logic [1:0] LF_PIN = 2'h2;
  // Reset cause codes
  localparam logic [1:0] CAUSE_POR = 2'h0;
  localparam logic [1:0] CAUSE_PIN = 2'h1;
  localparam logic [1:0] CAUSE_WAKE = 2'h2;
  // Settle time between gating and power removal
  localparam int GATE_NS = 40;
  localparam int CLK_NS = 8;
  localparam int GATE_CYC = (GATE_NS + CLK_NS - 1) / CLK_NS;
  // Length of the internal reset sequence
  localparam int RST_NS = 160;
  localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
endpackage

//--- src/pms_seq.sv
// Power-mode sequencer with clock gating, I/O latch and reset cause
`timescale 1ns/1ps
module pms_seq #(
  parameter int NIO = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic mode_req,
  input wire logic [1:0] mode_sel,
  input wire logic irq_any,
  input wire logic rtc_evt,
  input wire logic sensor_evt,
  input wire logic ext_wake,
  input wire logic [NIO-1:0] io_in,
  input wire logic [NIO-1:0] sd_wake_en,
  input wire logic [1:0] lf_sel,
  input wire logic lf_out_en,
  input wire logic rc_osc_low,
  input wire logic crystal_osc_low,
  input wire logic [NIO-1:0] lf_pin_clk,
  input wire logic [2:0] lf_pin_idx,
  input wire logic rc_osc_medium,
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic periph_clk_en,
  output logic flash_pwr,
  output logic periph_pwr,
  output logic sram_retain,
  output logic supply_duty,
  output logic brownout_detect_duty,
  output logic always_on_domain_pwr,
  output logic sensor_pwr,
  output logic io_latch,
  output logic [NIO-1:0] io_hold,
  output logic always_on_watchdog_run,
  output logic ordinary_watchdog_pause,
  output logic sys_rst_n,
  output logic [1:0] reset_cause,
  output logic low_speed_sys_clock,
  output logic medium_speed_sys_clock,
  output logic lf_pin_out,
  output logic lf_pin_oe,
  output logic radio_resync
);
  // Whole module state in one record
  typedef struct packed {
    pms_pkg::pms_state_t st;
    logic [pms_pkg::CNT_W-1:0] cnt;
    logic [NIO-1:0] hold;
    logic [1:0] cause;
    logic cpu_ce, mem_ce, per_ce, fl_pw, per_pw, ret, duty;
    logic aon_pw, sen_pw, latch, aon_wd, wd_pause, rst_n;
    logic lf, mf, lfo, lfoe, resync;
  } pms_regs_t;

  pms_regs_t s_q;
  pms_regs_t s_d;
  logic lf_src;
  logic wake_sb;
  logic wake_sd;

  // Low-speed source mux; pin source reaches any I/O via index
  always_comb
  begin
    case (lf_sel)
      pms_pkg::LF_XTAL: lf_src = crystal_osc_low;
      pms_pkg::LF_PIN: lf_src = lf_pin_clk[lf_pin_idx];
      default: lf_src = rc_osc_low;
    endcase
  end

  // Standby wakes to active only on these three; interrupts alone do not count
  assign wake_sb = ext_wake | rtc_evt | sensor_evt;
  // Any enabled pin differing from its held level wakes shutdown
  assign wake_sd = |((io_in ^ s_q.hold) & sd_wake_en);

  // Next-state and output decode
  always_comb
  begin
    s_d = s_q;
    s_d.mf = rc_osc_medium;
    s_d.lf = lf_src;
    // Output only for RC or crystal; a pin source is not echoed
    s_d.lfoe = lf_out_en && (lf_sel != pms_pkg::LF_PIN);
    s_d.lfo = s_d.lfoe & lf_src;
    s_d.resync = 1'b0;
    if (s_q.cnt != '0)
      s_d.cnt = s_q.cnt - 1'b1;
    case (s_q.st)
      pms_pkg::ST_ACTIVE:
      begin
        s_d.cpu_ce = 1'b1;
        s_d.mem_ce = 1'b1;
        s_d.per_ce = 1'b1;
        s_d.fl_pw = 1'b1;
        s_d.per_pw = 1'b1;
        s_d.ret = 1'b0;
        s_d.duty = 1'b0;
        s_d.aon_pw = 1'b1;
        s_d.sen_pw = 1'b1;
        s_d.latch = 1'b0;
        s_d.aon_wd = 1'b1;
        s_d.wd_pause = 1'b0;
        s_d.rst_n = 1'b1;
        if (mode_req)
        begin
          // Clocks stop first; power waits for the gate timer
          s_d.cpu_ce = 1'b0;
          s_d.mem_ce = 1'b0;
          s_d.cnt = pms_pkg::CNT_W'(pms_pkg::GATE_CYC);
          case (mode_sel)
            pms_pkg::REQ_IDLE: s_d.st = pms_pkg::ST_IDLE;
            pms_pkg::REQ_STANDBY:
            begin
              s_d.st = pms_pkg::ST_GATE_SB;
              s_d.per_ce = 1'b0;
              s_d.latch = 1'b1;
              s_d.hold = io_in;
            end
            pms_pkg::REQ_SHUTDOWN:
            begin
              s_d.st = pms_pkg::ST_GATE_SD;
              s_d.per_ce = 1'b0;
              s_d.latch = 1'b1;
              s_d.hold = io_in;
            end
            default:
            begin
              // Unknown code is ignored, so the CPU keeps its clocks
              s_d.cpu_ce = 1'b1;
              s_d.mem_ce = 1'b1;
            end
          endcase
        end
      end
      pms_pkg::ST_IDLE:
      begin
        s_d.cpu_ce = 1'b0;
        s_d.mem_ce = 1'b0;
        if (irq_any)
        begin
          s_d.st = pms_pkg::ST_ACTIVE;
          s_d.cpu_ce = 1'b1;
          s_d.mem_ce = 1'b1;
        end
      end
      pms_pkg::ST_GATE_SB:
        if (s_q.cnt == '0)
        begin
          s_d.st = pms_pkg::ST_STANDBY;
          s_d.fl_pw = 1'b0;
          s_d.per_pw = 1'b0;
          s_d.ret = 1'b1;
          s_d.duty = 1'b1;
          s_d.wd_pause = 1'b1;
          s_d.resync = 1'b1;
        end
      pms_pkg::ST_STANDBY:
        if (wake_sb)
        begin
          // Registers untouched, so CPU resumes in place
          s_d.st = pms_pkg::ST_ACTIVE;
          s_d.resync = 1'b1;
        end
      pms_pkg::ST_GATE_SD:
        if (s_q.cnt == '0)
        begin
          s_d.st = pms_pkg::ST_SHUTDOWN;
          s_d.fl_pw = 1'b0;
          s_d.per_pw = 1'b0;
          s_d.ret = 1'b0;
          s_d.aon_pw = 1'b0;
          s_d.sen_pw = 1'b0;
          s_d.aon_wd = 1'b0;
          s_d.wd_pause = 1'b0;
          s_d.rst_n = 1'b0;
        end
      pms_pkg::ST_SHUTDOWN:
        if (wake_sd)
        begin
          s_d.st = pms_pkg::ST_RESET;
          s_d.cause = pms_pkg::CAUSE_WAKE;
          s_d.cnt = pms_pkg::CNT_W'(pms_pkg::RST_CYC);
        end
      pms_pkg::ST_RESET:
      begin
        s_d.rst_n = 1'b0;
        s_d.latch = 1'b0;
        s_d.aon_pw = 1'b1;
        if (s_q.cnt == '0)
          s_d.st = pms_pkg::ST_ACTIVE;
      end
      default: s_d.st = pms_pkg::ST_RESET;
    endcase
    // Reset pin overrides every state, shutdown included
    if (!reset_pin_n)
    begin
      s_d.st = pms_pkg::ST_RESET;
      s_d.cause = pms_pkg::CAUSE_PIN;
      s_d.cnt = pms_pkg::CNT_W'(pms_pkg::RST_CYC);
      s_d.rst_n = 1'b0;
      s_d.cpu_ce = 1'b0;
      s_d.mem_ce = 1'b0;
      s_d.latch = 1'b0;
    end
  end

  // State register; power-on leaves cause at power-on code
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.st <= pms_pkg::ST_RESET;
      s_q.cnt <= pms_pkg::CNT_W'(pms_pkg::RST_CYC);
      s_q.cause <= pms_pkg::CAUSE_POR;
      s_q.aon_pw <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign cpu_clk_en = s_q.cpu_ce;
  assign mem_clk_en = s_q.mem_ce;
  assign periph_clk_en = s_q.per_ce;
  assign flash_pwr = s_q.fl_pw;
  assign periph_pwr = s_q.per_pw;
  assign sram_retain = s_q.ret;
  assign supply_duty = s_q.duty;
  assign brownout_detect_duty = s_q.duty;
  assign always_on_domain_pwr = s_q.aon_pw;
  assign sensor_pwr = s_q.sen_pw;
  assign io_latch = s_q.latch;
  assign io_hold = s_q.hold;
  assign always_on_watchdog_run = s_q.aon_wd;
  assign ordinary_watchdog_pause = s_q.wd_pause;
  assign sys_rst_n = s_q.rst_n;
  assign reset_cause = s_q.cause;
  assign low_speed_sys_clock = s_q.lf;
  assign medium_speed_sys_clock = s_q.mf;
  assign lf_pin_out = s_q.lfo;
  assign lf_pin_oe = s_q.lfoe;
  assign radio_resync = s_q.resync;

  // Idle: CPU clock off, peripherals still clocked
  a_idle_gating: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == pms_pkg::ST_IDLE |-> !cpu_clk_en && periph_clk_en)
    else $error("idle gating wrong");
  a_idle_irq_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == pms_pkg::ST_IDLE && irq_any && reset_pin_n
    |=> s_q.st == pms_pkg::ST_ACTIVE && cpu_clk_en)
    else $error("idle did not wake on interrupt");
  a_sb_power: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == pms_pkg::ST_STANDBY |-> !flash_pwr && sram_retain
    && always_on_domain_pwr && supply_duty && io_latch)
    else $error("standby power wrong");
  a_sb_no_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == pms_pkg::ST_STANDBY && !wake_sb && reset_pin_n
    |=> s_q.st == pms_pkg::ST_STANDBY)
    else $error("standby left without wake source");
  a_sb_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == pms_pkg::ST_STANDBY |=> $stable(io_hold))
    else $error("pins moved in standby");
  sequence sd_req_s;
    s_q.st == pms_pkg::ST_ACTIVE && mode_req && reset_pin_n
    && mode_sel == pms_pkg::REQ_SHUTDOWN;
  endsequence
  a_sd_order: assert property (@(posedge clk_sys) disable iff (!nrst)
    sd_req_s |=> io_latch && !cpu_clk_en && always_on_domain_pwr
    && io_hold == $past(io_in))
    else $error("shutdown entry order wrong");
  a_sd_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == pms_pkg::ST_SHUTDOWN && wake_sd && reset_pin_n
    |=> !sys_rst_n && reset_cause == pms_pkg::CAUSE_WAKE)
    else $error("shutdown pin wake failed");
  a_rst_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
    !reset_pin_n |=> !sys_rst_n && reset_cause == pms_pkg::CAUSE_PIN)
    else $error("reset pin ignored");
  a_wdt_modes: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == pms_pkg::ST_SHUTDOWN |-> !always_on_watchdog_run
    && !always_on_domain_pwr && !sensor_pwr)
    else $error("shutdown domains still on");
  a_lf_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    lf_pin_oe |-> $past(lf_sel) != pms_pkg::LF_PIN)
    else $error("pin clock echoed out");
endmodule

//--- tb/pms_partner.sv
// Far-side model: oscillators and standby wake sources
`timescale 1ns/1ps
module pms_partner (
  input wire logic clk_sys,
  input wire logic [1:0] fire,
  output logic rtc_evt,
  output logic sensor_evt,
  output logic ext_wake,
  output logic rc_osc_low,
  output logic crystal_osc_low,
  output logic rc_osc_medium
);
  int div_q;
  // Start quiet; every output here moves only on falling edges
  initial
  begin
    div_q = 0;
    {rtc_evt, sensor_evt, ext_wake} = 3'h0;
    {rc_osc_low, crystal_osc_low, rc_osc_medium} = 3'h0;
  end
  // Oscillators toggle on falling edges so the sampling rising edge never
  // races them; unequal periods let the bench tell the sources apart
  always @(negedge clk_sys)
  begin
    div_q <= div_q + 1;
    if (div_q % 3 == 0)
      rc_osc_low <= ~rc_osc_low;
    if (div_q % 5 == 0)
      crystal_osc_low <= ~crystal_osc_low;
    if (div_q % 2 == 0)
      rc_osc_medium <= ~rc_osc_medium;
    // One-cycle wake pulses; fire is read one edge late to avoid races
    rtc_evt <= (fire == 2'h1);
    sensor_evt <= (fire == 2'h2);
    ext_wake <= (fire == 2'h3);
  end
endmodule

//--- tb/pms_seq_test.sv
// Self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
module pms_seq_test;
  typedef struct packed {logic [31:0] m; logic [31:0] v;} pms_note_t;
  localparam logic [31:0] ACT_M = 32'h0200_ffff;
  localparam logic [31:0] ACT_V = 32'h0000_f8d4;
  logic clk_sys, nrst, reset_pin_n, mode_req, irq_any, lf_out_en;
  logic rtc_evt, sensor_evt, ext_wake;
  logic rc_osc_low, crystal_osc_low, rc_osc_medium;
  logic [1:0] mode_sel, lf_sel, fire, reset_cause;
  logic [7:0] io_in, sd_wake_en, lf_pin_clk, io_hold, io_v;
  logic [2:0] lf_pin_idx;
  logic cpu_clk_en, mem_clk_en, periph_clk_en, flash_pwr, periph_pwr;
  logic sram_retain, supply_duty, brownout_detect_duty, sensor_pwr;
  logic always_on_domain_pwr, io_latch, always_on_watchdog_run;
  logic ordinary_watchdog_pause, sys_rst_n, low_speed_sys_clock;
  logic medium_speed_sys_clock, lf_pin_out, lf_pin_oe, radio_resync;
  int errors, checks_done, seed_v;
  pms_note_t notes[$];
  pms_note_t nt;

  pms_seq dut (.clk_sys, .nrst, .reset_pin_n, .mode_req, .mode_sel,
    .irq_any, .rtc_evt, .sensor_evt, .ext_wake, .io_in, .sd_wake_en,
    .lf_sel, .lf_out_en, .rc_osc_low, .crystal_osc_low, .lf_pin_clk,
    .lf_pin_idx, .rc_osc_medium, .cpu_clk_en, .mem_clk_en, .periph_clk_en,
    .flash_pwr, .periph_pwr, .sram_retain, .supply_duty,
    .brownout_detect_duty, .always_on_domain_pwr, .sensor_pwr, .io_latch,
    .io_hold, .always_on_watchdog_run, .ordinary_watchdog_pause, .sys_rst_n,
    .reset_cause, .low_speed_sys_clock, .medium_speed_sys_clock,
    .lf_pin_out, .lf_pin_oe, .radio_resync);
  pms_partner far (.clk_sys, .fire, .rtc_evt, .sensor_evt, .ext_wake,
    .rc_osc_low, .crystal_osc_low, .rc_osc_medium);

  // Status word: resync at 25, oe at 24, held pins 23:16, states 15:0
  function automatic logic [31:0] obs();
    return {6'h0, radio_resync, lf_pin_oe, io_hold, cpu_clk_en, mem_clk_en,
      periph_clk_en,
      flash_pwr, periph_pwr, sram_retain, supply_duty, brownout_detect_duty,
      always_on_domain_pwr, sensor_pwr, io_latch, always_on_watchdog_run,
      ordinary_watchdog_pause, sys_rst_n, reset_cause};
  endfunction
  // Low-speed source that the select code asks for
  function automatic logic lf_exp();
    case (lf_sel)
      pms_pkg::LF_XTAL: return crystal_osc_low;
      pms_pkg::LF_PIN: return lf_pin_clk[lf_pin_idx];
      default: return rc_osc_low;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic note(input logic [31:0] m, input logic [31:0] v);
    notes.push_back('{m, v});
  endtask
  // Requests are held one full cycle so exactly one edge takes them
  task automatic request(input logic [1:0] sel);
    mode_sel = sel;
    mode_req = 1'b1;
    tick(1);
    mode_req = 1'b0;
  endtask
  // Bounded wait: a hung reset sequence counts as a mismatch
  task automatic wait_active();
    int n;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
    check(32'(n >= 60), 32'h0000_0000);
    tick(1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Compare notes a little after the falling edge, when outputs are settled
  always @(negedge clk_sys)
  begin
    #1;
    while (notes.size() > 0)
    begin
      nt = notes.pop_front();
      check(obs() & nt.m, nt.v & nt.m);
    end
  end
  // Clock outputs follow their source one edge late; sources move only on
  // falling edges, so just after the rising edge both must agree
  always @(posedge clk_sys)
  begin
    #1;
    if (nrst)
    begin
      check(32'(medium_speed_sys_clock), 32'(rc_osc_medium));
      check(32'(low_speed_sys_clock), 32'(lf_exp()));
      check(32'(lf_pin_out),
        32'(lf_out_en && lf_sel != pms_pkg::LF_PIN && lf_exp()));
    end
  end
  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  initial
  begin
    {nrst, mode_req, irq_any, lf_out_en, mode_sel, lf_sel} = 8'h00;
    {reset_pin_n, fire, io_in, sd_wake_en, lf_pin_idx} = 22'h20_0000;
    seed_v = $urandom(32'h0000_05be);
    lf_pin_clk = 8'($urandom);
    tick(4);
    nrst = 1'b1;
    wait_active();
    note(ACT_M, ACT_V);
    request(pms_pkg::REQ_IDLE);
    tick(1);
    note(32'h0000_e018, 32'h0000_2010);
    irq_any = 1'b1;
    tick(1);
    irq_any = 1'b0;
    tick(3);
    note(ACT_M, ACT_V);
    // An unknown mode code must leave the CPU running
    request(2'h3);
    note(ACT_M, ACT_V);
    tick(1);
    $display("test idle done");
    for (int k = 1; k < 4; k++)
    begin
      io_v = 8'($urandom);
      io_in = io_v;
      request(pms_pkg::REQ_STANDBY);
      tick(1);
      note(32'h00ff_f020, {8'h00, io_v, 16'h1020});
      tick(5);
      note(32'h02ff_9ff8, {8'h02, io_v, 16'h07f8});
      tick(1);
      io_in = ~io_v;
      irq_any = 1'b1;
      tick(3);
      irq_any = 1'b0;
      note(32'h00ff_8000, {8'h00, io_v, 16'h0000});
      fire <= 2'(k);
      tick(1);
      fire <= 2'h0;
      tick(1);
      note(32'h0200_8000, 32'h0200_0000);
      tick(3);
      note(ACT_M, ACT_V);
    end
    $display("test standby done");
    io_v = 8'($urandom);
    io_in = io_v;
    sd_wake_en = 8'h01;
    request(pms_pkg::REQ_SHUTDOWN);
    tick(7);
    note(32'h00ff_90f0, {8'h00, io_v, 16'h0020});
    io_in = io_v ^ 8'h80;
    tick(3);
    note(32'h0000_0080, 32'h0000_0000);
    io_in = io_v ^ 8'h81;
    tick(2);
    note(32'h0000_0007, 32'h0000_0002);
    wait_active();
    note(ACT_M, ACT_V | 32'h0000_0002);
    $display("test shutdown done");
    request(pms_pkg::REQ_STANDBY);
    tick(8);
    reset_pin_n = 1'b0;
    tick(2);
    note(32'h0000_0007, 32'h0000_0001);
    reset_pin_n = 1'b1;
    wait_active();
    note(ACT_M, ACT_V | 32'h0000_0001);
    $display("test reset pin done");
    for (int k = 0; k < 3; k++)
    begin
      lf_sel = 2'(k);
      lf_out_en = 1'b1;
      lf_pin_idx = 3'($urandom);
      lf_pin_clk = 8'($urandom);
      // Long enough for the slowest oscillator to toggle under the monitor
      tick(12);
      note(32'h0100_0000, {7'h0, 2'(k) != pms_pkg::LF_PIN, 24'h0});
    end
    tick(2);
    $display("test clock out done");
    close_out();
  end
endmodule
